// file: logic/smbus_target.sv
// target end: address match, pointer register, small register file
// assumes the bus clock is slow against ref_clk_i and passes two flops
`timescale 1ns/10ps
module smbus_target
    import smbus_pkg::*;
#(
    parameter int timeout_limit = timeout_cycles,  // idle cycles before release
    parameter int reg_count     = 256              // registers behind the pointer
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // straps and configuration
    input  wire logic       address_enable_strap_i,
    input  wire logic       address_select_strap_i,
    input  wire logic [7:0] config_i,              // bit 6 disables the timeout
    // bus
    smbus_if.target         bus,
    // register write port for the user side
    output logic            reg_wr_o,
    output logic [7:0]      reg_wr_addr_o,
    output logic [7:0]      reg_wr_data_o,
    output logic [7:0]      pointer_o,
    output logic [6:0]      slave_addr_o,
    output logic            addr_locked_o
);
    typedef enum {st_idle, st_addr, st_ack, st_rx, st_tx, st_txack} state_e;

    logic [2:0] scl_sync;          // synchroniser plus edge history
    logic [2:0] sda_sync;
    logic       scl_rise;          // sampled clock rising
    logic       scl_fall;          // sampled clock falling
    logic       start_det;         // data falls while clock high
    logic       stop_det;          // data rises while clock high
    state_e     state;
    logic [3:0] bit_cnt;           // bits seen in current byte
    logic [7:0] shift;             // incoming byte
    logic [7:0] tx;                // outgoing byte
    logic       rd_dir;            // direction of operation
    logic [1:0] wr_bytes;          // bytes written after address
    logic [1:0] enable_sync;       // enable strap pin, two flops
    logic [1:0] select_sync;       // select strap pin, two flops
    logic       strap_taken;       // straps caught after reset
    logic [6:0] strap_addr;        // address chosen by straps
    logic [7:0] regs [reg_count];  // internal register file
    logic [31:0] idle_cnt;         // cycles without bus movement
    logic [6:0] next_addr;

    // two flops, then a third stage only for edge history
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], bus.scl};
            sda_sync <= {sda_sync[1:0], bus.sda};
        end
    end
    assign scl_rise  = scl_sync[1] & ~scl_sync[2];
    assign scl_fall  = ~scl_sync[1] & scl_sync[2];
    assign start_det = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    assign stop_det  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

    // straps are pins: two flops before the address choice reads them,
    // free running so they already hold the pin levels when reset ends
    always_ff @(posedge ref_clk_i) begin
        enable_sync <= {enable_sync[0], address_enable_strap_i};
        select_sync <= {select_sync[0], address_select_strap_i};
    end

    // address from the straps
    always_comb begin
        if (enable_sync[1]) begin
            next_addr = addr_default;
        end else if (select_sync[1]) begin
            next_addr = addr_select_hi;
        end else begin
            next_addr = addr_select_lo;
        end
    end

    // straps caught first cycle after reset release, tracked until locked
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            strap_taken   <= 1'b0;
            strap_addr    <= addr_default;
            addr_locked_o <= 1'b0;
        end else begin
            if (!strap_taken || !addr_locked_o) begin
                strap_addr  <= next_addr;
                strap_taken <= 1'b1;
            end
            // lock on rising edge of eighth clock when seven bits match
            if (state == st_addr && scl_rise && bit_cnt == 4'(bits_per_byte - 1)
                && shift[6:0] == strap_addr) begin
                addr_locked_o <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            slave_addr_o <= addr_default;
        end else begin
            slave_addr_o <= strap_addr;
        end
    end

    // idle watchdog; counts only while a transfer is open, any clock edge clears it
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || scl_rise || scl_fall || state == st_idle) begin
            idle_cnt <= 32'h0;
        end else if (idle_cnt < timeout_limit) begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    // main bit-level state machine
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state    <= st_idle;
            bit_cnt  <= 4'h0;
            shift    <= 8'h0;
            tx       <= 8'h0;
            rd_dir   <= 1'b0;
            wr_bytes <= 2'h0;
            pointer_o <= 8'h0;
            reg_wr_o <= 1'b0;
            reg_wr_addr_o <= 8'h0;
            reg_wr_data_o <= 8'h0;
            bus.sda_oe_s  <= 1'b0;
        end else begin
            reg_wr_o <= 1'b0;
            if (start_det) begin
                state        <= st_addr;
                bit_cnt      <= 4'h0;
                wr_bytes     <= 2'h0;
                bus.sda_oe_s <= 1'b0;
            end else if (stop_det || (!config_i[timeout_bit]
                         && idle_cnt >= timeout_limit)) begin
                state        <= st_idle;
                bus.sda_oe_s <= 1'b0;
            end else begin
                case (state)
                    st_idle: bus.sda_oe_s <= 1'b0;
                    st_addr, st_rx: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'(bits_per_byte)) begin
                            bit_cnt <= 4'h0;
                            if (state == st_addr) begin
                                rd_dir <= shift[0];
                                if (shift[7:1] == strap_addr) begin
                                    bus.sda_oe_s <= 1'b1;
                                    state <= st_ack;
                                end else begin
                                    state <= st_idle;
                                end
                            end else if (wr_bytes == 2'h0) begin
                                pointer_o    <= shift;
                                wr_bytes     <= 2'h1;
                                bus.sda_oe_s <= 1'b1;
                                state        <= st_ack;
                            end else if (wr_bytes == 2'h1) begin
                                regs[pointer_o] <= shift;
                                reg_wr_o      <= 1'b1;
                                reg_wr_addr_o <= pointer_o;
                                reg_wr_data_o <= shift;
                                wr_bytes      <= 2'h2;
                                bus.sda_oe_s  <= 1'b1;
                                state         <= st_ack;
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    st_ack: begin
                        // release after the ninth clock, or drive the first data bit for a read
                        if (scl_fall) begin
                            bus.sda_oe_s <= 1'b0;
                            if (rd_dir) begin
                                tx           <= regs[pointer_o];
                                bus.sda_oe_s <= ~regs[pointer_o][7];
                                bit_cnt      <= 4'h1;
                                state        <= st_tx;
                            end else begin
                                state <= st_rx;
                            end
                        end
                    end
                    st_tx: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'(bits_per_byte)) begin
                                bus.sda_oe_s <= 1'b0;
                                state        <= st_txack;
                            end else begin
                                bus.sda_oe_s <= ~tx[3'(7 - bit_cnt)];
                                bit_cnt      <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    // one byte only: master nack or ack, then wait for stop
                    st_txack: if (scl_fall) state <= st_idle;
                    default: state <= st_idle;
                endcase
            end
        end
    end
endmodule

// file: logic/smbus_pkg.sv
// package of constants shared by the bus target and bus master ends
// assumes a single 250 MHz clock on both ends and an open-drain wired bus
package smbus_pkg;
    localparam logic [6:0] addr_default   = 7'h2e;     // enable strap high
    localparam logic [6:0] addr_select_lo = 7'h2c;     // select strap low
    localparam logic [6:0] addr_select_hi = 7'h2d;     // select strap high
    localparam int         clk_mhz        = 250;
    localparam int         timeout_ms     = 35;
    localparam int         timeout_cycles = timeout_ms * clk_mhz * 1000;
    localparam int         timeout_bit    = 6;         // timeout disable bit position
    localparam int         half_period    = 20;        // master tick period, a quarter of an scl bit, cycles
    localparam int         bits_per_byte  = 8;
endpackage

// file: logic/smbus_if.sv
// wired two-line bus joining the master end and the target end
// assumes both ends drive open-drain style: enable high pulls the line low
`timescale 1ns/10ps
interface smbus_if;
    logic scl_oe_m;   // master pulls clock low
    logic sda_oe_m;   // master pulls data low
    logic sda_oe_s;   // target pulls data low
    logic scl;        // resolved clock level
    logic sda;        // resolved data level
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_s);
    modport target (input scl, input sda, output sda_oe_s);
    modport master (input scl, input sda, output scl_oe_m, output sda_oe_m);
endinterface

// file: logic/smbus_master.sv
// master end: runs send, write, receive and read byte operations
// assumes the target answers on the wired bus; clock made by a divider
`timescale 1ns/10ps
module smbus_master
    import smbus_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // command port
    input  wire logic       cmd_valid_i,
    input  wire logic [6:0] cmd_addr_i,
    input  wire logic       cmd_read_i,     // 1 read, 0 write
    input  wire logic       cmd_two_i,      // write carries a data byte
    input  wire logic       cmd_restart_i,  // send or write ends with repeated start; a read always ends with stop
    input  wire logic [7:0] cmd_ptr_i,
    input  wire logic [7:0] cmd_data_i,
    // answers
    output logic            busy_o,
    output logic            done_o,
    output logic            nack_o,
    output logic [7:0]      rd_data_o,
    // bus
    smbus_if.master         bus
);
    typedef enum {m_idle, m_start, m_bits, m_stop, m_rs} mstate_e;
    mstate_e    state;
    logic [7:0] div;            // quarter-bit tick divider
    logic       tick;           // one-cycle phase enable
    logic [1:0] ph;             // quarter phase within a bit
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;       // 0 addr, 1 ptr, 2 data
    logic [8:0] sh;             // byte plus ack slot
    logic       rd, two, rs;
    logic [7:0] ptr, dat;
    logic [1:0] sda_s;          // synchronised data line

    assign tick = (div == 8'(half_period - 1));
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || tick) div <= 8'h0;
        else div <= div + 8'h1;
    end
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) sda_s <= 2'h3;
        else sda_s <= {sda_s[0], bus.sda};
    end

    // sequencer; each bit is four ticks, clock low for two then high for two
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state <= m_idle;
            bus.scl_oe_m <= 1'b0;
            bus.sda_oe_m <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            nack_o <= 1'b0;
            rd_data_o <= 8'h0;
            ph <= 2'h0;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            sh <= 9'h0;
            rd <= 1'b0;
            two <= 1'b0;
            rs <= 1'b0;
            ptr <= 8'h0;
            dat <= 8'h0;
        end else begin
            done_o <= 1'b0;
            case (state)
                m_idle: if (cmd_valid_i) begin
                    busy_o <= 1'b1;
                    nack_o <= 1'b0;
                    rd  <= cmd_read_i;
                    two <= cmd_two_i;
                    rs  <= cmd_restart_i;
                    ptr <= cmd_ptr_i;
                    dat <= cmd_data_i;
                    sh  <= {cmd_addr_i, cmd_read_i, 1'b1};
                    ph  <= 2'h0;
                    state <= m_start;
                end
                m_start: if (tick) begin
                    bus.sda_oe_m <= 1'b1;
                    byte_idx <= 2'h0;
                    bit_cnt  <= 4'h0;
                    ph       <= 2'h0;
                    state    <= m_bits;
                end
                m_bits: if (tick) begin
                    ph <= ph + 2'h1;
                    if (ph == 2'h0) begin
                        bus.scl_oe_m <= 1'b1;                 // clock low
                    end else if (ph == 2'h1) begin
                        bus.sda_oe_m <= ~sh[8];
                    end else if (ph == 2'h2) begin
                        bus.scl_oe_m <= 1'b0;                 // clock high
                    end else begin
                        sh <= {sh[7:0], 1'b1};
                        if (bit_cnt == 4'(bits_per_byte)) begin
                            bit_cnt <= 4'h0;
                            if (sda_s[1] && !(rd && byte_idx == 2'h1)) nack_o <= 1'b1;
                            if (rd && byte_idx == 2'h1) begin
                                state <= m_stop;
                            end else if (sda_s[1] || (rd && byte_idx == 2'h0)) begin
                                if (sda_s[1]) state <= m_stop;
                                else begin
                                    byte_idx <= 2'h1;
                                    sh <= 9'h1ff;             // release for read byte
                                end
                            end else if (byte_idx == 2'h0) begin
                                byte_idx <= 2'h1;
                                sh <= {ptr, 1'b1};
                            end else if (byte_idx == 2'h1 && two) begin
                                byte_idx <= 2'h2;
                                sh <= {dat, 1'b1};
                            end else begin
                                state <= rs ? m_rs : m_stop;
                            end
                        end else begin
                            if (rd && byte_idx == 2'h1) rd_data_o <= {rd_data_o[6:0], sda_s[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                m_stop, m_rs: if (tick) begin
                    ph <= ph + 2'h1;
                    if (ph == 2'h0) bus.scl_oe_m <= 1'b1;
                    else if (ph == 2'h1) bus.sda_oe_m <= (state == m_stop);
                    else if (ph == 2'h2) bus.scl_oe_m <= 1'b0;
                    else begin
                        bus.sda_oe_m <= 1'b0;                 // stop, or idle-high before restart
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state  <= m_idle;
                    end
                end
                default: state <= m_idle;
            endcase
        end
    end
endmodule

// file: dv/smbus_bus_sva.sv
// checker on the wired bus lines between the master end and the target end
// assumes the lines are sampled by the same clock and reset as both ends
`timescale 1ns/10ps
module smbus_bus_sva (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // bus lines as seen on the interface
    input  wire logic scl_oe_m,
    input  wire logic sda_oe_m,
    input  wire logic sda_oe_s,
    input  wire logic scl,
    input  wire logic sda
);
    logic       scl_q;     // clock level one cycle ago
    logic       sda_q;     // data level one cycle ago
    logic [3:0] bit_pos;   // clock pulse within the byte, 0 right after start
    logic [1:0] byte_idx;  // bytes since start, saturating at 3

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // line history, reset to the idle level so no false edge follows reset
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // frame position; byte_idx parks at 3 so idle never looks like an address byte
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            bit_pos  <= 4'h0;
            byte_idx <= 2'h3;
        end else if (scl && scl_q && sda_q && !sda) begin  // start opens a frame
            bit_pos  <= 4'h0;
            byte_idx <= 2'h0;
        end else if (scl && !scl_q) begin  // clock rise
            bit_pos  <= (bit_pos == 4'h9) ? 4'h1 : bit_pos + 4'h1;
            byte_idx <= (bit_pos == 4'h9 && byte_idx != 2'h3) ? byte_idx + 2'h1 : byte_idx;
        end
    end

    sequence s_start;
        scl && scl_q && sda_q && !sda;
    endsequence
    sequence s_stop;
        scl && scl_q && !sda_q && sda;
    endsequence
    sequence s_rise;
        scl && !scl_q;
    endsequence

    a_start_clock_high: assert property (s_start |-> scl[*8])
        else $error("clock fell too soon after start");
    a_stop_after_ack: assert property (s_stop |-> bit_pos == 4'h1)
        else $error("stop not in the pulse after an acknowledge");
    a_address_bits_quiet: assert property
        (s_rise ##0 (byte_idx == 2'h0 && bit_pos < 4'h8) |-> !sda_oe_s)
        else $error("target drove data during the address bits");
    a_ack_from_target: assert property
        (s_rise ##0 (byte_idx == 2'h0 && bit_pos == 4'h8) |-> !sda_oe_m)
        else $error("master drove the address acknowledge");
    a_target_holds_high: assert property (s_rise ##0 sda_oe_s |-> sda_oe_s[*8])
        else $error("target released data while clock high");
    a_target_moves_low: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("target changed data while clock high");
    a_master_data_hold: assert property
        (scl && scl_q && bit_pos >= 4'h2 && bit_pos <= 4'h9 |-> $stable(sda_oe_m))
        else $error("master changed data while clock high");
    a_clock_high_min: assert property (s_rise |-> !scl_oe_m[*8])
        else $error("clock high period too short");
    c_address_acked: cover property (s_rise ##0 (byte_idx == 2'h0 && bit_pos == 4'h8 && sda_oe_s));
endmodule

// file: dv/tb.sv
// self-checking bench: master end and target end joined on one wired bus
// assumes package address constants and a shortened bus timeout
`timescale 1ns/10ps
module tb
    import smbus_pkg::*;
();
    logic       ref_clk_i, reset_n_i;               // clock and reset
    logic       address_enable_strap_i, address_select_strap_i;
    logic [7:0] config_i;                            // bit 6 disables timeout
    logic       cmd_valid_i, cmd_read_i, cmd_two_i, cmd_restart_i;
    logic [6:0] cmd_addr_i;
    logic [7:0] cmd_ptr_i, cmd_data_i;
    logic       busy_o, done_o, nack_o, reg_wr_o, addr_locked_o;
    logic [7:0] rd_data_o, reg_wr_addr_o, reg_wr_data_o, pointer_o;
    logic [6:0] slave_addr_o;
    int         mismatches, comparisons, wr_count;   // counters
    logic [7:0] wr_addr_seen, wr_data_seen;          // last register write seen
    smbus_if bus_w ();
    smbus_target #(.timeout_limit(2000)) smbus_target_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .address_enable_strap_i(address_enable_strap_i),
        .address_select_strap_i(address_select_strap_i), .config_i(config_i),
        .bus(bus_w), .reg_wr_o(reg_wr_o), .reg_wr_addr_o(reg_wr_addr_o),
        .reg_wr_data_o(reg_wr_data_o), .pointer_o(pointer_o),
        .slave_addr_o(slave_addr_o), .addr_locked_o(addr_locked_o));
    smbus_master smbus_master_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_addr_i(cmd_addr_i), .cmd_read_i(cmd_read_i), .cmd_two_i(cmd_two_i),
        .cmd_restart_i(cmd_restart_i), .cmd_ptr_i(cmd_ptr_i), .cmd_data_i(cmd_data_i),
        .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o),
        .bus(bus_w));
    smbus_bus_sva smbus_bus_sva_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_oe_m(bus_w.scl_oe_m),
        .sda_oe_m(bus_w.sda_oe_m), .sda_oe_s(bus_w.sda_oe_s), .scl(bus_w.scl),
        .sda(bus_w.sda));

    // 250 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // count register writes; the pulse lasts one cycle so each edge is looked at
    always @(posedge ref_clk_i) begin
        if (reg_wr_o === 1'b1) begin
            wr_count++;
            wr_addr_seen = reg_wr_addr_o;
            wr_data_seen = reg_wr_data_o;
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // byte-wide results; single flags are zero-extended by the caller
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one whole bus operation; waits for the done pulse under a bound
    task automatic run_cmd(input logic [6:0] a, input logic rd, input logic two,
                           input logic rst, input logic [7:0] p, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        #1;
        cmd_valid_i = 1'b1;
        cmd_addr_i = a;
        cmd_read_i = rd;
        cmd_two_i = two;
        cmd_restart_i = rst;
        cmd_ptr_i = p;
        cmd_data_i = d;
        @(posedge ref_clk_i);  // master idle, so this edge takes the command
        #1;
        cmd_valid_i = 1'b0;
        chk_byte("busy_o", 8'h01, {7'h00, busy_o});
        while (done_o !== 1'b1 && n < 4000) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (n >= 4000) begin
            mismatches++;
            $display("unexpected done_o: expected 1 seen 0");
            tally_and_finish();
        end
        chk_byte("busy_o", 8'h00, {7'h00, busy_o});
    endtask

    // wrong addresses are not acknowledged and change nothing
    task automatic t_foreign_addr();
        chk_byte("slave_addr_o", {1'b0, addr_select_hi}, {1'b0, slave_addr_o});
        run_cmd(addr_default, 1'b0, 1'b0, 1'b0, 8'h33, 8'h00);
        chk_byte("nack_o", 8'h01, {7'h00, nack_o});
        run_cmd(addr_select_lo, 1'b0, 1'b1, 1'b0, 8'h44, 8'h55);
        chk_byte("nack_o", 8'h01, {7'h00, nack_o});
        chk_byte("pointer_o", 8'h00, pointer_o);
        chk_byte("wr_count", 8'h00, wr_count[7:0]);
        chk_byte("addr_locked_o", 8'h00, {7'h00, addr_locked_o});
        $display("test foreign_addr done");
    endtask

    // send byte sets the pointer only, and locks the address against strap changes
    task automatic t_send_byte();
        run_cmd(addr_select_hi, 1'b0, 1'b0, 1'b0, 8'h10, 8'h00);
        chk_byte("nack_o", 8'h00, {7'h00, nack_o});
        chk_byte("pointer_o", 8'h10, pointer_o);
        chk_byte("wr_count", 8'h00, wr_count[7:0]);
        chk_byte("addr_locked_o", 8'h01, {7'h00, addr_locked_o});
        address_enable_strap_i = 1'b1;
        address_select_strap_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk_byte("slave_addr_o", {1'b0, addr_select_hi}, {1'b0, slave_addr_o});
        $display("test send_byte done");
    endtask

    // two write bytes in a row, then receive byte from the last pointer
    task automatic t_write_read();
        run_cmd(addr_select_hi, 1'b0, 1'b1, 1'b0, 8'h10, 8'ha5);
        chk_byte("nack_o", 8'h00, {7'h00, nack_o});
        chk_byte("reg_wr_addr_o", 8'h10, wr_addr_seen);
        chk_byte("reg_wr_data_o", 8'ha5, wr_data_seen);
        run_cmd(addr_select_hi, 1'b0, 1'b1, 1'b0, 8'h3c, 8'h5e);
        chk_byte("pointer_o", 8'h3c, pointer_o);
        chk_byte("wr_count", 8'h02, wr_count[7:0]);
        run_cmd(addr_select_hi, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        chk_byte("nack_o", 8'h00, {7'h00, nack_o});
        chk_byte("rd_data_o", 8'h5e, rd_data_o);
        $display("test write_read done");
    endtask

    // send byte ending in repeated start, read straight after; timeout disabled
    task automatic t_restart_read();
        config_i = 8'h40;
        run_cmd(addr_select_hi, 1'b0, 1'b0, 1'b1, 8'h10, 8'h00);
        chk_byte("pointer_o", 8'h10, pointer_o);
        run_cmd(addr_select_hi, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        chk_byte("nack_o", 8'h00, {7'h00, nack_o});
        chk_byte("rd_data_o", 8'ha5, rd_data_o);
        $display("test restart_read done");
    endtask

    // second reset: enable strap high, then straps followed until a match locks
    task automatic t_strap_reset();
        reset_n_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk_byte("slave_addr_o", {1'b0, addr_default}, {1'b0, slave_addr_o});
        address_enable_strap_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk_byte("slave_addr_o", {1'b0, addr_select_lo}, {1'b0, slave_addr_o});
        run_cmd(addr_select_lo, 1'b0, 1'b0, 1'b0, 8'h21, 8'h00);
        chk_byte("nack_o", 8'h00, {7'h00, nack_o});
        $display("test strap_reset done");
    endtask

    initial begin
        reset_n_i = 1'b0;
        address_enable_strap_i = 1'b0;
        address_select_strap_i = 1'b1;
        config_i = 8'h00;
        cmd_valid_i = 1'b0;
        cmd_addr_i = 7'h00;
        {cmd_read_i, cmd_two_i, cmd_restart_i} = 3'h0;
        {cmd_ptr_i, cmd_data_i} = 16'h0000;
        {mismatches, comparisons, wr_count} = '0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        t_foreign_addr();
        t_send_byte();
        t_write_read();
        t_restart_read();
        t_strap_reset();
        tally_and_finish();
    end
endmodule
